// file: aim_i2c_master.sv
// Two-wire bus controller that reaches the converter's registers
`timescale 1ns/1ps
module aim_i2c_master
	import aim_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial clock, open drain
	output logic scl_o,
	output logic scl_oe_n,
	input wire logic scl_i,
	// Serial data, open drain
	output logic sda_o,
	output logic sda_oe_n,
	input wire logic sda_i
);
	typedef struct packed {
		aim_st_e st;
		logic [1:0] ph;
		logic [13:0] stall;
		logic [3:0] bitc;
		logic [1:0] bidx;
		logic [7:0] sh;
		logic ack_bad;
		aim_op_e op;
		logic [7:0] ptr;
		logic [6:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic scl_lo;
		logic sda_lo;
		logic nack;
		logic done;
		logic [31:0] prdata;
	} aim_mst_s;

	aim_mst_s s_reg;
	aim_mst_s s_next;
	logic tick;
	logic sda_s;
	logic scl_s;
	logic hit;
	logic rx;
	logic [1:0] last;

	////////////////////////////////////////////////////////////////////////
	// Pins and timing

	aim_sync #(.W(1)) u_sync_sda (
		.clk(pclk),
		.rst_n(presetn),
		.d(sda_i),
		.q(sda_s)
	);

	aim_sync #(.W(1)) u_sync_scl (
		.clk(pclk),
		.rst_n(presetn),
		.d(scl_i),
		.q(scl_s)
	);

	aim_tick_div u_div (
		.clk(pclk),
		.rst_n(presetn),
		.tick(tick)
	);

	// Open drain: only ever pull low, the pull-ups make the high level
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_n = ~s_reg.scl_lo;
	assign sda_oe_n = ~s_reg.sda_lo;

	////////////////////////////////////////////////////////////////////////
	// Frame helpers

	function automatic logic [1:0] byte_count(aim_op_e op);
		case (op)
			OP_READ: byte_count = 2'd2;
			OP_WRITE: byte_count = 2'd3;
			default: byte_count = 2'd1;
		endcase
	endfunction

	function automatic logic [7:0] tx_byte(aim_op_e op, logic [1:0] idx,
		logic [7:0] ptr, logic [15:0] wd);
		case (idx)
			2'd1: tx_byte = (op == OP_GCALL) ? GCALL_RESET : ptr;
			2'd2: tx_byte = wd[15:8];
			default: tx_byte = wd[7:0];
		endcase
	endfunction

	assign last = byte_count(s_reg.op);
	assign rx = (s_reg.op == OP_READ) && (s_reg.bidx != 2'd0);
	assign hit = (paddr == REG_CMD) || (paddr == REG_ADDR) || (paddr == REG_WDATA)
		|| (paddr == REG_RDATA) || (paddr == REG_STAT);

	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata = s_reg.prdata;

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		s_next = s_reg;
		// Read data is latched in the setup cycle so it stands through access
		if (psel && !penable)
		begin
			case (paddr)
				REG_CMD: s_next.prdata = {16'h0000, s_reg.ptr, 6'h00, s_reg.op};
				REG_ADDR: s_next.prdata = {25'h0000000, s_reg.addr};
				REG_WDATA: s_next.prdata = {16'h0000, s_reg.wdata};
				REG_RDATA: s_next.prdata = {16'h0000, s_reg.rdata};
				REG_STAT: s_next.prdata = {29'h00000000, s_reg.done, s_reg.nack,
					s_reg.st != ST_IDLE};
				default: s_next.prdata = 32'h00000000;
			endcase
		end
		if (psel && penable && pwrite)
		begin
			if (paddr == REG_ADDR)
				s_next.addr = pwdata[6:0];
			if (paddr == REG_WDATA)
				s_next.wdata = pwdata[15:0];
			// A command while a frame runs is dropped; poll busy first
			if (paddr == REG_CMD && s_reg.st == ST_IDLE)
			begin
				s_next.op = aim_op_e'(pwdata[CMD_OP_LSB +: 2]);
				s_next.ptr = pwdata[CMD_PTR_LSB +: 8];
				s_next.st = ST_START;
				s_next.ph = 2'd0;
				s_next.nack = 1'b0;
				s_next.done = 1'b0;
			end
		end
		if (tick)
		begin
			s_next.ph = s_reg.ph + 2'd1;
			case (s_reg.st)
				ST_START:
				begin
					if (s_reg.ph == 2'd1)
						s_next.sda_lo = 1'b1;
					if (s_reg.ph == 2'd3)
					begin
						s_next.st = ST_BIT;
						s_next.scl_lo = 1'b1;
						s_next.bitc = 4'h0;
						s_next.bidx = 2'd0;
						s_next.sh = {(s_reg.op == OP_GCALL) ? GCALL_ADDR : s_reg.addr,
							s_reg.op == OP_READ};
					end
				end
				ST_BIT:
				begin
					case (s_reg.ph)
						2'd0:
						begin
							// Data moves a quarter after clock falls, never with it
							if (s_reg.bitc != ACK_BIT)
								s_next.sda_lo = rx ? 1'b0 : ~s_reg.sh[7];
							else
								s_next.sda_lo = rx && (s_reg.bidx != last);
						end
						2'd1:
							s_next.scl_lo = 1'b0;
						2'd2:
						begin
							// Hold the phase until the line is really high
							if (!scl_s)
							begin
								s_next.ph = s_reg.ph;
								s_next.stall = s_reg.stall + 14'h0001;
								// The device has dropped the frame by now, so drop it too
								if (s_reg.stall == STALL_LAST)
								begin
									s_next.st = ST_STOP;
									s_next.ph = 2'd0;
									s_next.stall = 14'h0000;
									s_next.scl_lo = 1'b1;
									s_next.nack = 1'b1;
								end
							end
							else if (s_reg.bitc != ACK_BIT)
								s_next.sh = {s_reg.sh[6:0], sda_s};
							else
								s_next.ack_bad = sda_s;
						end
						default:
						begin
							s_next.scl_lo = 1'b1;
							s_next.ph = 2'd0;
							s_next.stall = 14'h0000;
							if (s_reg.bitc != ACK_BIT)
								s_next.bitc = s_reg.bitc + 4'h1;
							else
							begin
								if (rx && s_reg.bidx == 2'd1)
									s_next.rdata[15:8] = s_reg.sh;
								if (rx && s_reg.bidx == 2'd2)
									s_next.rdata[7:0] = s_reg.sh;
								if (!rx && s_reg.ack_bad)
								begin
									s_next.nack = 1'b1;
									s_next.st = ST_STOP;
								end
								else if (s_reg.bidx == last)
									s_next.st = ST_STOP;
								else
								begin
									s_next.bidx = s_reg.bidx + 2'd1;
									s_next.bitc = 4'h0;
									s_next.sh = tx_byte(s_reg.op, s_reg.bidx + 2'd1,
										s_reg.ptr, s_reg.wdata);
								end
							end
						end
					endcase
				end
				ST_STOP:
				begin
					case (s_reg.ph)
						2'd0:
							s_next.sda_lo = 1'b1;
						2'd1:
							s_next.scl_lo = 1'b0;
						2'd2:
							s_next.sda_lo = 1'b0;
						default:
						begin
							s_next.st = ST_IDLE;
							s_next.done = 1'b1;
						end
					endcase
				end
				default:
					s_next.ph = 2'd0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_reg <= '0;
			s_reg.addr <= ADDR_RST;
			s_reg.rdata <= RESULT_RST;
		end
		else
			s_reg <= s_next;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	localparam int LOW_CYC = 2 * QTR_CYC;
	logic [15:0] lo_cnt;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lo_cnt <= 16'h0000;
		else if (s_reg.scl_lo)
			lo_cnt <= lo_cnt + 16'h0001;
		else
			lo_cnt <= 16'h0000;
	end

	sequence s_start_edge;
		!s_reg.scl_lo && $rose(s_reg.sda_lo);
	endsequence

	sequence s_stop_edge;
		!s_reg.scl_lo && $fell(s_reg.sda_lo);
	endsequence

	property p_sda_stable;
		@(posedge pclk) disable iff (!presetn)
		(s_reg.st == ST_BIT && !s_reg.scl_lo && $past(!s_reg.scl_lo))
			|-> $stable(s_reg.sda_lo);
	endproperty
	a_sda_stable: assert property (p_sda_stable)
		else $error("data moved while clock high");

	property p_start_only;
		@(posedge pclk) disable iff (!presetn)
		s_start_edge |-> s_reg.st == ST_START;
	endproperty
	a_start_only: assert property (p_start_only)
		else $error("data fell under high clock outside start");

	property p_stop_only;
		@(posedge pclk) disable iff (!presetn)
		s_stop_edge |-> s_reg.st == ST_STOP ##[1:300] s_reg.st == ST_IDLE;
	endproperty
	a_stop_only: assert property (p_stop_only)
		else $error("data rose under high clock outside stop");

	property p_idle_high;
		@(posedge pclk) disable iff (!presetn)
		s_reg.st == ST_IDLE |-> !s_reg.scl_lo && !s_reg.sda_lo;
	endproperty
	a_idle_high: assert property (p_idle_high)
		else $error("line held low while idle");

	property p_addr_dir;
		@(posedge pclk) disable iff (!presetn)
		(s_reg.st == ST_BIT && $past(s_reg.st) == ST_START)
			|-> s_reg.sh[0] == (s_reg.op == OP_READ)
			&& s_reg.sh[7:1] == ((s_reg.op == OP_GCALL) ? GCALL_ADDR : s_reg.addr);
	endproperty
	a_addr_dir: assert property (p_addr_dir)
		else $error("address byte wrong");

	property p_low_time;
		@(posedge pclk) disable iff (!presetn)
		$fell(s_reg.scl_lo) |-> lo_cnt == LOW_CYC;
	endproperty
	a_low_time: assert property (p_low_time)
		else $error("clock low time off rate");

	property p_hi_then_lo;
		@(posedge pclk) disable iff (!presetn)
		($changed(s_reg.rdata[15:8]) |-> s_reg.bidx == 2'd2)
			and ($changed(s_reg.rdata[7:0]) |-> s_reg.st == ST_STOP);
	endproperty
	a_hi_then_lo: assert property (p_hi_then_lo)
		else $error("read bytes stored out of order");

	property p_read_ack;
		@(posedge pclk) disable iff (!presetn)
		(s_reg.st == ST_BIT && rx && s_reg.bitc == ACK_BIT && s_reg.ph != 2'd0)
			|-> s_reg.sda_lo == (s_reg.bidx != last);
	endproperty
	a_read_ack: assert property (p_read_ack)
		else $error("read acknowledge wrong");

	property p_cfg_bytes;
		@(posedge pclk) disable iff (!presetn)
		($rose(s_reg.st == ST_STOP) && s_reg.op == OP_WRITE && !s_reg.nack)
			|-> s_reg.bidx == 2'd3;
	endproperty
	a_cfg_bytes: assert property (p_cfg_bytes)
		else $error("write frame short of three bytes");
endmodule

// file: aim_pkg.sv
// Constants, types and register map of the converter link controller
// Summary of operation
// - Link runs at 100 or 400 kbit/s; this controller runs at 100 kbit/s only
// - Data changes only while clock is low
// - Frames open with START, close with STOP
// - Address seven bits, then direction bit
// - Whole bytes, most significant bit first
// - After 25 ms idle, abandon and restart; this controller drops a frame stalled 25 ms with nack set, no restart
// - High byte first, then low byte
// - Pointer write frame, then read frame
// - Configuration write: pointer plus two bytes
// - Controller keeps clock high when idle
package aim_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int BIT_RATE_HZ = 100_000;
	localparam int QTR_CYC = CLK_HZ / (4 * BIT_RATE_HZ);
	localparam int QTR_W = 7;
	localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);
	// 25 ms of clock; a line held low that long has reset the device's port
	localparam int IDLE_LIMIT_CYC = CLK_HZ / 40;
	localparam logic [13:0] STALL_LAST = 14'(IDLE_LIMIT_CYC / QTR_CYC - 1);

	// Controller registers on the bus
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0c;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_PTR_LSB = 8;
	localparam int STAT_BUSY = 0;
	localparam int STAT_NACK = 1;
	localparam int STAT_DONE = 2;

	// Device side numbers
	localparam logic [6:0] ADDR_STRAP_GND = 7'h48;
	localparam logic [6:0] ADDR_STRAP_VDD = 7'h49;
	localparam logic [6:0] ADDR_STRAP_SCL = 7'h4b;
	localparam logic [6:0] ADDR_RST = ADDR_STRAP_GND;
	localparam logic [6:0] GCALL_ADDR = 7'h00;
	localparam logic [7:0] GCALL_RESET = 8'h06;
	localparam logic [7:0] PTR_RESULT = 8'h00;
	localparam logic [7:0] PTR_CONFIG = 8'h01;
	localparam logic [15:0] RESULT_RST = 16'h0000;
	localparam logic [3:0] ACK_BIT = 4'h8;

	typedef enum logic [1:0] {
		OP_PTR = 2'h0,
		OP_READ = 2'h1,
		OP_WRITE = 2'h2,
		OP_GCALL = 2'h3
	} aim_op_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_BIT = 2'b11,
		ST_STOP = 2'b10
	} aim_st_e;
endpackage

// file: aim_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module aim_sync
	import aim_pkg::*;
#(
	parameter int W = 1
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Asynchronous in, synchronous out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] held;
	} aim_sync_s;

	aim_sync_s s_reg;
	aim_sync_s s_next;

	always_comb
	begin
		s_next.meta = d;
		s_next.held = s_reg.meta;
	end

	// Idle bus reads high, so the chain resets to ones
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_reg <= '1;
		else
			s_reg <= s_next;
	end

	assign q = s_reg.held;
endmodule

// file: aim_tick_div.sv
// Quarter-bit enable pulse for the serial link
`timescale 1ns/1ps
module aim_tick_div
	import aim_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// One-cycle pulse every quarter bit
	output logic tick
);
	typedef struct packed {
		logic [QTR_W-1:0] cnt;
		logic tick;
	} aim_div_s;

	aim_div_s s_reg;
	aim_div_s s_next;

	always_comb
	begin
		s_next = s_reg;
		s_next.tick = (s_reg.cnt == QTR_LAST);
		if (s_reg.cnt == QTR_LAST)
			s_next.cnt = '0;
		else
			s_next.cnt = s_reg.cnt + 7'h01;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign tick = s_reg.tick;
endmodule

// file: aim_dev_model.sv
// Behavioural model of the converter's two-wire register port
`timescale 1ns/1ps
module aim_dev_model
	import aim_pkg::*;
#(
	parameter logic [15:0] CFG_RST = 16'h8583
)
(
	// Bus wires, never drives the clock
	input wire logic scl,
	input wire logic sda,
	output logic sda_oe_n,
	// Strap and converter side
	input wire logic [1:0] addr_sel,
	input wire logic conv_load,
	input wire logic [11:0] conv_data
);
	logic [15:0] result_reg;
	logic [15:0] config_reg;
	logic [7:0] ptr_reg;
	logic [7:0] rx;
	logic [7:0] tx;
	logic [7:0] hi;
	logic [6:0] my_addr;
	logic [3:0] cnt;
	logic [1:0] nbyte;
	// 0 address, 1 write, 2 read, 3 ignore until next START
	logic [1:0] mode;
	logic act, gcall, mack, rd_lo;

	initial
	begin
		result_reg = RESULT_RST;
		config_reg = CFG_RST;
		ptr_reg = PTR_RESULT;
		sda_oe_n = 1'b1;
		act = 1'b0;
		mode = 2'h3;
	end

	always @(posedge conv_load)
		// A 12-bit code cannot pass the clip codes 7ff0h and 8000h
		result_reg = {conv_data, 4'h0};

	always @(negedge sda)
		if (scl === 1'b1)
		begin
			act = 1'b1;
			mode = 2'h0;
			// The clock fall that closes START carries no bit; it wraps this to zero
			cnt = 4'hf;
			sda_oe_n = 1'b1;
			my_addr = addr_sel == 2'h0 ? ADDR_STRAP_GND :
				addr_sel == 2'h1 ? ADDR_STRAP_VDD : ADDR_STRAP_SCL;
		end

	always @(posedge sda)
		if (scl === 1'b1)
		begin
			act = 1'b0;
			sda_oe_n = 1'b1;
		end

	// Sample while the clock is high; data only moves while it is low
	always @(posedge scl)
		if (act)
		begin
			if (cnt < 4'h8)
				rx = {rx[6:0], sda};
			else
				mack = !sda;
		end

	always @(negedge scl)
		if (act && mode != 2'h3)
		begin
			if (cnt == 4'h7)
			begin
				cnt = 4'h8;
				sda_oe_n = 1'b1;
				if (mode == 2'h0)
				begin
					gcall = rx == {GCALL_ADDR, 1'b0};
					nbyte = 2'h0;
					rd_lo = 1'b0;
					mode = (rx[7:1] == my_addr || gcall) ? (rx[0] ? 2'h2 : 2'h1) : 2'h3;
					sda_oe_n = mode == 2'h3;
				end
				else if (mode == 2'h1)
				begin
					sda_oe_n = 1'b0;
					if (gcall)
					begin
						if (rx == GCALL_RESET)
						begin
							result_reg = RESULT_RST;
							config_reg = CFG_RST;
							ptr_reg = PTR_RESULT;
						end
					end
					else if (nbyte == 2'h0)
						ptr_reg = rx;
					else if (nbyte == 2'h1)
						hi = rx;
					else if (ptr_reg == PTR_CONFIG)
						config_reg = {hi, rx};
					nbyte = nbyte == 2'h2 ? 2'h1 : nbyte + 2'h1;
				end
			end
			else if (cnt == 4'h8)
			begin
				cnt = 4'h0;
				sda_oe_n = 1'b1;
				if (mode == 2'h2 && mack)
				begin
					tx = ptr_reg == PTR_RESULT ? (rd_lo ? result_reg[7:0] : result_reg[15:8]) :
						(rd_lo ? config_reg[7:0] : config_reg[15:8]);
					rd_lo = !rd_lo;
					sda_oe_n = tx[7];
				end
				else if (mode == 2'h2)
					mode = 2'h3;
			end
			else
			begin
				cnt = cnt + 4'h1;
				if (mode == 2'h2)
					sda_oe_n = tx[7 - cnt];
			end
		end
endmodule

// file: aim_i2c_master_test.sv
// Self-checking bench of the converter link controller
`timescale 1ns/1ps
module aim_i2c_master_test
	import aim_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic scl_o, scl_oe_n, sda_o, sda_oe_n, dev_oe_n, conv_load, e;
	logic [1:0] addr_sel;
	logic [11:0] conv_data;
	logic [15:0] cfg;
	int miscompares, check_count;
	int cyc = 0;
	wire scl = scl_oe_n;
	// Open drain with pull-up: low if anybody pulls
	wire sda = sda_oe_n & dev_oe_n;

	aim_i2c_master dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .scl_i(scl), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n), .sda_i(sda));
	aim_dev_model dev (.scl(scl), .sda(sda), .sda_oe_n(dev_oe_n), .addr_sel(addr_sel),
		.conv_load(conv_load), .conv_data(conv_data));

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic summarize;
		$display("mismatches %0d, checks %0d", miscompares, check_count);
		if (miscompares == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// The frames need about 97k cycles in all; a hang ends here
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 104000)
		begin
			miscompares++;
			summarize;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Start a frame and wait for busy to drop
	task automatic frame(input logic [1:0] op, input logic [7:0] ptr, input logic nack);
		apb(1'b1, REG_CMD, {16'h0, ptr, 6'h0, op});
		do
		begin
			apb(1'b0, REG_STAT, 32'h0);
		end
		while (q[STAT_BUSY] !== 1'b0);
		chk(q & 32'h7, {29'h0, 1'b1, nack, 1'b0});
	endtask

	task automatic rd(input logic [15:0] exp);
		frame(OP_READ, PTR_RESULT, 1'b0);
		apb(1'b0, REG_RDATA, 32'h0);
		chk(q, {16'h0, exp});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		addr_sel = 2'h0;
		conv_load = 1'b0;
		conv_data = 12'h0;
		miscompares = 0;
		check_count = 0;
		void'($urandom(32'h962f10a7));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, REG_ADDR, 32'h0);
		chk(q, {25'h0, ADDR_RST});
		apb(1'b0, 8'h14, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		// Data aimed at the read-only result must vanish
		apb(1'b1, REG_WDATA, {16'h0, 16'($urandom)});
		frame(OP_WRITE, PTR_RESULT, 1'b0);
		rd(RESULT_RST);
		addr_sel <= 2'h1;
		frame(OP_PTR, PTR_CONFIG, 1'b1);
		apb(1'b1, REG_ADDR, {25'h0, ADDR_STRAP_VDD});
		cfg = 16'($urandom);
		apb(1'b1, REG_WDATA, {16'h0, cfg});
		frame(OP_WRITE, PTR_CONFIG, 1'b0);
		rd(cfg);
		conv_data <= 12'($urandom) | 12'h800;
		conv_load <= 1'b1;
		addr_sel <= 2'h2;
		apb(1'b1, REG_ADDR, {25'h0, ADDR_STRAP_SCL});
		conv_load <= 1'b0;
		frame(OP_PTR, PTR_RESULT, 1'b0);
		rd({conv_data, 4'h0});
		frame(OP_GCALL, 8'h0, 1'b0);
		rd(RESULT_RST);
		chk({31'h0, scl}, 32'h1);
		summarize;
	end
endmodule
